// ---- pkg/fsc_pkg.sv ----
`default_nettype none
package fsc_pkg;
   // register indices, byte address is four times the index
   localparam logic [9:0] IDX_ENABLE = 10'h240;
   localparam logic [9:0] IDX_DIVIDER = 10'h241;
   localparam logic [9:0] IDX_NUMER = 10'h242;
   localparam logic [9:0] IDX_INTMUL = 10'h243;
   localparam logic [9:0] IDX_REFBYP = 10'h244;
   localparam logic [9:0] IDX_DENOM = 10'h246;
   localparam logic [9:0] IDX_FRMODE = 10'h247;
   localparam logic [9:0] IDX_STATUS = 10'h248;
   localparam int ADDR_W = 12;
   localparam int WORD_LSB = 2;

   // bits that hold state, all others read as zero
   localparam logic [15:0] MASK_ENABLE = 16'h0003;
   localparam logic [15:0] MASK_DIVIDER = 16'h3f07;
   localparam logic [15:0] MASK_NUMER = 16'hffff;
   localparam logic [15:0] MASK_INTMUL = 16'h7fe0;
   localparam logic [15:0] MASK_REFBYP = 16'h9fdb;
   localparam logic [15:0] MASK_DENOM = 16'hffff;
   localparam logic [15:0] MASK_FRMODE = 16'h0007;

   // reset values that are not zero
   localparam logic [15:0] RST_REFBYP = 16'h0c80;
   localparam logic [15:0] RST_FRMODE = 16'h0006;

   // field positions
   localparam int ENA_BIT = 0;
   localparam int OSC_BIT = 1;
   localparam int OUTDIV_LSB = 8;
   localparam int RATIO_LSB = 0;
   localparam int INTMUL_LSB = 5;
   localparam int BYP_BIT = 15;
   localparam int NCOVAL_LSB = 7;
   localparam int NCOSEL_BIT = 6;
   localparam int PREDIV_LSB = 3;
   localparam int SRC_LSB = 0;
   localparam int EFS_BIT = 0;

   // status word bits
   localparam int LOCK_BIT = 0;
   localparam int HOLD_BIT = 1;
   localparam int FREE_BIT = 2;
   localparam int RUN_BIT = 3;

   // divider limits
   localparam logic [5:0] OUTDIV_MIN = 6'h03;
   localparam logic [4:0] RATIO_MAX_LAST = 5'h0f;
   localparam int FREE_SHIFT = 8;

   typedef enum logic [1:0] {
      SRC_MCLK_A = 2'b00,
      SRC_MCLK_B = 2'b01,
      SRC_FRAME = 2'b10,
      SRC_BIT = 2'b11
   } fsc_src_t;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // reference loss time before holdover
   localparam longint CLK_HZ = 20000000;
   localparam longint REF_LOSS_US = 1000;
   localparam int REF_LOSS_CYCLES = int'(REF_LOSS_US * CLK_HZ / 1000000);
endpackage
`default_nettype wire

// ---- hdl/fsc_ref_divider.sv ----
`default_nettype none
module fsc_ref_divider (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // reference pins
   input wire logic masterClockInA,
   input wire logic masterClockInB,
   input wire logic port2FrameClock,
   input wire logic port2BitClock,
   // selection
   input wire logic [1:0] refSourceSelect,
   input wire logic [1:0] refPredivider,
   // one pulse per divided reference period
   output logic refTick
);
   typedef struct packed {
      logic prev;
      logic [2:0] cnt;
      logic tick;
   } fsc_refdiv_t;

   fsc_refdiv_t st_reg, st_next;
   logic pin;
   logic [2:0] lastCount;

   // source multiplexer
   always_comb begin
      case (fsc_pkg::fsc_src_t'(refSourceSelect)) // [RULE_09]
         fsc_pkg::SRC_MCLK_A: pin = masterClockInA;
         fsc_pkg::SRC_MCLK_B: pin = masterClockInB;
         fsc_pkg::SRC_FRAME: pin = port2FrameClock;
         fsc_pkg::SRC_BIT: pin = port2BitClock;
         default: pin = masterClockInA;
      endcase
   end

   // divide by 1, 2, 4 or 8 counted in rising edges
   assign lastCount = 3'((4'h1 << refPredivider) - 4'h1); // [RULE_09]

   always_comb begin
      st_next = st_reg;
      st_next.prev = pin;
      st_next.tick = 1'b0;
      if (pin && !st_reg.prev) begin
         if (st_reg.cnt >= lastCount) begin
            st_next.cnt = 3'h0;
            st_next.tick = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 3'h1;
         end
      end
      if (rst) begin
         st_next = '0;
      end
   end

   always_ff @(posedge ref_clk) begin
      st_reg <= st_next;
   end

   assign refTick = st_reg.tick;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_ref_edge: assert property ( // [RULE_09]
      (pin && !st_reg.prev && refPredivider == 2'b00) |=> refTick)
      else $error("undivided reference edge gave no tick");
endmodule
`default_nettype wire

// ---- hdl/fsc_out_divider.sv ----
`default_nettype none
module fsc_out_divider (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // oscillator events
   input wire logic vcoTick,
   input wire logic run,
   input wire logic [5:0] outputDivider,
   // divided clock level
   output logic divClk
);
   typedef struct packed {
      logic [5:0] cnt;
      logic clk;
   } fsc_outdiv_t;

   fsc_outdiv_t st_reg, st_next;
   logic [5:0] lastCode;
   logic [5:0] half;

   // reserved codes behave as the smallest legal divide
   assign lastCode = (outputDivider < fsc_pkg::OUTDIV_MIN) ?
                     fsc_pkg::OUTDIV_MIN : outputDivider; // [RULE_02]
   assign half = 6'((7'(lastCode) + 7'h01) >> 1);

   // count code+1 events per output period, high for the first half
   always_comb begin
      st_next = st_reg;
      if (!run) begin
         st_next = '0;
      end else if (vcoTick) begin
         st_next.cnt = (st_reg.cnt >= lastCode) ? 6'h00 : st_reg.cnt + 6'h01; // [RULE_02]
         st_next.clk = st_next.cnt < half;
      end
      if (rst) begin
         st_next = '0;
      end
   end

   always_ff @(posedge ref_clk) begin
      st_reg <= st_next;
   end

   assign divClk = st_reg.clk;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_div_wrap: assert property ( // [RULE_02]
      (run && vcoTick && st_reg.cnt == lastCode) ##1 run |-> st_reg.cnt == 6'h00)
      else $error("output divider did not wrap at code plus one");
endmodule
`default_nettype wire

// ---- hdl/fsc_config.sv ----
// What this block does
// RULE_01 - software sets the enable bit last, after all other fields
// RULE_02 - output divider code n divides by n+1; codes below three reserved
// RULE_03 - reference ratio codes give 1, 2, 4, 8; top bit set gives 16
// RULE_04 - ten-bit integer multiplier, resets to zero
// RULE_05 - sixteen-bit fraction numerator and denominator, both reset to zero
// RULE_06 - fractional mode bit selects integer or fractional multiplication
// RULE_07 - software leaves the two reserved mode bits at binary 11
// RULE_08 - bypass takes the output straight from the port-2 bit clock
// RULE_09 - reference source select and predivide by 1, 2, 4 or 8
// RULE_10 - output clock exists without any reference, at reduced accuracy
// RULE_11 - after reference loss the output keeps its last frequency
// RULE_12 - oscillator enable, divide by 8 and forced code 19h give 12MHz
// RULE_13 - software programs audio port rates matching the core clock select
// RULE_14 - forced select runs the oscillator at the forced code value
// RULE_15 - oscillator enable bit exists for free running, resets off
// RULE_16 - loop locks oscillator ticks per reference to ratio times N.K
// RULE_17 - output held low when disabled and neither bypass nor free run
`default_nettype none
module fsc_config #(
   parameter int RefLossCycles = fsc_pkg::REF_LOSS_CYCLES
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // axi4-lite write channels
   input wire logic [fsc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read channels
   input wire logic [fsc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // reference pins
   input wire logic masterClockInA,
   input wire logic masterClockInB,
   input wire logic port2FrameClock,
   input wire logic port2BitClock,
   // synthesized clock
   output logic synthClockOut
);
   if (RefLossCycles < 2 || RefLossCycles > 1048575) begin : g_bad_loss
      $error("RefLossCycles must lie between 2 and 2**20-1");
   end

   typedef struct packed {
      logic awRdy;
      logic wRdy;
      logic awHave;
      logic wHave;
      logic [9:0] awIdx;
      logic [15:0] wData;
      logic [1:0] wStrb;
      logic bVld;
      logic [1:0] bResp;
      logic arRdy;
      logic rVld;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic [15:0] rEnable;
      logic [15:0] rDivider;
      logic [15:0] rNumer;
      logic [15:0] rIntMul;
      logic [15:0] rRefByp;
      logic [15:0] rDenom;
      logic [15:0] rFrMode;
      logic [15:0] ncoAcc;
      logic [15:0] ncoInc;
      logic [4:0] ratioCnt;
      logic [10:0] winCnt;
      logic [15:0] fracAcc;
      logic [19:0] idleCnt;
      logic holdover;
      logic locked;
      logic armed;
      logic outClk;
   } fsc_state_t;

   fsc_state_t st_reg, st_next;

   // field views of the register file
   logic synthEnable, freeOscEnable, bypassSelect, forcedOscSelect;
   logic fractionalModeEnable, freeRun, run;
   logic [5:0] outputDivider, forcedOscCode;
   logic [2:0] vcoRefRatio;
   logic [9:0] integerMultiplier;
   logic [1:0] refPredivider, refSourceSelect;
   logic [15:0] fracNumerator, fracDenominator, statusWord;

   assign synthEnable = st_reg.rEnable[fsc_pkg::ENA_BIT];
   assign freeOscEnable = st_reg.rEnable[fsc_pkg::OSC_BIT]; // [RULE_15]
   assign outputDivider = st_reg.rDivider[fsc_pkg::OUTDIV_LSB +: 6];
   assign vcoRefRatio = st_reg.rDivider[fsc_pkg::RATIO_LSB +: 3];
   assign fracNumerator = st_reg.rNumer;
   assign integerMultiplier = st_reg.rIntMul[fsc_pkg::INTMUL_LSB +: 10];
   assign bypassSelect = st_reg.rRefByp[fsc_pkg::BYP_BIT];
   assign forcedOscCode = st_reg.rRefByp[fsc_pkg::NCOVAL_LSB +: 6];
   assign forcedOscSelect = st_reg.rRefByp[fsc_pkg::NCOSEL_BIT];
   assign refPredivider = st_reg.rRefByp[fsc_pkg::PREDIV_LSB +: 2];
   assign refSourceSelect = st_reg.rRefByp[fsc_pkg::SRC_LSB +: 2];
   assign fracDenominator = st_reg.rDenom;
   assign fractionalModeEnable = st_reg.rFrMode[fsc_pkg::EFS_BIT];

   // free running needs both the oscillator and the forced code select
   assign freeRun = freeOscEnable && forcedOscSelect; // [RULE_10] [RULE_14]
   assign run = synthEnable || freeRun;

   always_comb begin
      statusWord = 16'h0000;
      statusWord[fsc_pkg::LOCK_BIT] = st_reg.locked;
      statusWord[fsc_pkg::HOLD_BIT] = st_reg.holdover;
      statusWord[fsc_pkg::FREE_BIT] = freeRun;
      statusWord[fsc_pkg::RUN_BIT] = run;
   end

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] data,
                                         input logic [1:0] strb, input logic [15:0] mask);
      logic [15:0] m;
      m = {{8{strb[1]}}, {8{strb[0]}}} & mask;
      return (old & ~m) | (data & m);
   endfunction

   function automatic logic [4:0] ratioLastOf(input logic [2:0] code);
      logic [4:0] r;
      r = code[2] ? fsc_pkg::RATIO_MAX_LAST : 5'((6'h01 << code[1:0]) - 6'h01);
      return r;
   endfunction

   // divided reference and output divider
   logic refTick, divClk;

   fsc_ref_divider u_ref (
      .ref_clk(ref_clk),
      .rst(rst),
      .masterClockInA(masterClockInA),
      .masterClockInB(masterClockInB),
      .port2FrameClock(port2FrameClock),
      .port2BitClock(port2BitClock),
      .refSourceSelect(refSourceSelect),
      .refPredivider(refPredivider),
      .refTick(refTick)
   );

   // oscillator model: phase accumulator overflow is one oscillator event
   logic [16:0] ncoSum, fracSum;
   logic vcoTick, preTick, fracCarry, loopUpdate;
   logic [4:0] ratioLast;
   logic [10:0] target;
   logic [15:0] fracWrap;

   assign ncoSum = {1'b0, st_reg.ncoAcc} + {1'b0, st_reg.ncoInc};
   assign vcoTick = run && ncoSum[16];
   assign ratioLast = ratioLastOf(vcoRefRatio); // [RULE_03]
   assign preTick = vcoTick && (st_reg.ratioCnt >= ratioLast);
   assign fracSum = {1'b0, st_reg.fracAcc} + {1'b0, fracNumerator};
   assign fracCarry = fractionalModeEnable && fracDenominator != 16'h0000 &&
                      fracSum >= {1'b0, fracDenominator}; // [RULE_05] [RULE_06]
   assign fracWrap = 16'(fracSum - {1'b0, fracDenominator});
   assign target = {1'b0, integerMultiplier} + {10'h000, fracCarry}; // [RULE_04] [RULE_16]
   // first window after enable or holdover is partial, so it only arms the loop
   assign loopUpdate = synthEnable && !freeRun && refTick && st_reg.armed && !st_reg.holdover;

   fsc_out_divider u_out (
      .ref_clk(ref_clk),
      .rst(rst),
      .vcoTick(vcoTick),
      .run(run),
      .outputDivider(outputDivider),
      .divClk(divClk)
   );

   // bus slave, register file and frequency loop
   always_comb begin
      st_next = st_reg;
      // write address and data are taken independently, one write at a time
      if (st_reg.awRdy && s_axi_awvalid) begin
         st_next.awRdy = 1'b0;
         st_next.awHave = 1'b1;
         st_next.awIdx = s_axi_awaddr[fsc_pkg::WORD_LSB +: 10];
      end
      if (st_reg.wRdy && s_axi_wvalid) begin
         st_next.wRdy = 1'b0;
         st_next.wHave = 1'b1;
         st_next.wData = s_axi_wdata[15:0];
         st_next.wStrb = s_axi_wstrb[1:0];
      end
      if (st_reg.awHave && st_reg.wHave && !st_reg.bVld) begin
         st_next.awHave = 1'b0;
         st_next.wHave = 1'b0;
         st_next.bVld = 1'b1;
         st_next.bResp = fsc_pkg::RESP_OKAY;
         case (st_reg.awIdx)
            fsc_pkg::IDX_ENABLE: st_next.rEnable = merge(st_reg.rEnable, st_reg.wData,
                                    st_reg.wStrb, fsc_pkg::MASK_ENABLE);
            fsc_pkg::IDX_DIVIDER: st_next.rDivider = merge(st_reg.rDivider, st_reg.wData,
                                     st_reg.wStrb, fsc_pkg::MASK_DIVIDER);
            fsc_pkg::IDX_NUMER: st_next.rNumer = merge(st_reg.rNumer, st_reg.wData,
                                   st_reg.wStrb, fsc_pkg::MASK_NUMER);
            fsc_pkg::IDX_INTMUL: st_next.rIntMul = merge(st_reg.rIntMul, st_reg.wData,
                                    st_reg.wStrb, fsc_pkg::MASK_INTMUL);
            fsc_pkg::IDX_REFBYP: st_next.rRefByp = merge(st_reg.rRefByp, st_reg.wData,
                                    st_reg.wStrb, fsc_pkg::MASK_REFBYP);
            fsc_pkg::IDX_DENOM: st_next.rDenom = merge(st_reg.rDenom, st_reg.wData,
                                   st_reg.wStrb, fsc_pkg::MASK_DENOM);
            fsc_pkg::IDX_FRMODE: st_next.rFrMode = merge(st_reg.rFrMode, st_reg.wData,
                                    st_reg.wStrb, fsc_pkg::MASK_FRMODE);
            fsc_pkg::IDX_STATUS: st_next.bResp = fsc_pkg::RESP_OKAY; // read only
            default: st_next.bResp = fsc_pkg::RESP_SLVERR;
         endcase
      end
      if (st_reg.bVld && s_axi_bready) begin
         st_next.bVld = 1'b0;
         st_next.awRdy = 1'b1;
         st_next.wRdy = 1'b1;
      end
      // reads answer on the edge that takes the address
      if (st_reg.arRdy && s_axi_arvalid) begin
         st_next.arRdy = 1'b0;
         st_next.rVld = 1'b1;
         st_next.rResp = fsc_pkg::RESP_OKAY;
         st_next.rData = 32'h00000000;
         case (s_axi_araddr[fsc_pkg::WORD_LSB +: 10])
            fsc_pkg::IDX_ENABLE: st_next.rData[15:0] = st_reg.rEnable;
            fsc_pkg::IDX_DIVIDER: st_next.rData[15:0] = st_reg.rDivider;
            fsc_pkg::IDX_NUMER: st_next.rData[15:0] = st_reg.rNumer;
            fsc_pkg::IDX_INTMUL: st_next.rData[15:0] = st_reg.rIntMul;
            fsc_pkg::IDX_REFBYP: st_next.rData[15:0] = st_reg.rRefByp;
            fsc_pkg::IDX_DENOM: st_next.rData[15:0] = st_reg.rDenom;
            fsc_pkg::IDX_FRMODE: st_next.rData[15:0] = st_reg.rFrMode;
            fsc_pkg::IDX_STATUS: st_next.rData[15:0] = statusWord;
            default: st_next.rResp = fsc_pkg::RESP_SLVERR;
         endcase
      end
      if (st_reg.rVld && s_axi_rready) begin
         st_next.rVld = 1'b0;
         st_next.arRdy = 1'b1;
      end

      // frequency loop, stopped and cleared while nothing runs, except the oscillator increment ncoInc, which keeps its value
      if (!run) begin
         st_next.ncoAcc = 16'h0000;
         st_next.ratioCnt = 5'h00;
         st_next.winCnt = 11'h000;
         st_next.fracAcc = 16'h0000;
         st_next.idleCnt = 20'h00000;
         st_next.holdover = 1'b0;
         st_next.locked = 1'b0;
         st_next.armed = 1'b0;
      end else begin
         st_next.ncoAcc = ncoSum[15:0];
         if (freeRun) begin
            st_next.ncoInc = 16'(forcedOscCode) << fsc_pkg::FREE_SHIFT; // [RULE_12] [RULE_14]
            st_next.locked = 1'b0;
         end
         if (vcoTick) begin
            st_next.ratioCnt = preTick ? 5'h00 : st_reg.ratioCnt + 5'h01; // [RULE_03]
         end
         if (preTick && st_reg.winCnt != 11'h7ff) begin
            st_next.winCnt = st_reg.winCnt + 11'h001;
         end
         if (synthEnable && !freeRun) begin
            if (refTick) begin
               st_next.idleCnt = 20'h00000;
               st_next.holdover = 1'b0;
               st_next.armed = 1'b1;
               st_next.winCnt = 11'h000;
               if (loopUpdate) begin
                  if (fracCarry) begin
                     st_next.fracAcc = fracWrap; // [RULE_05]
                  end else if (fractionalModeEnable) begin
                     st_next.fracAcc = fracSum[15:0]; // [RULE_06]
                  end
                  st_next.locked = st_reg.winCnt == target; // [RULE_16]
                  // one step per window keeps the loop slow and free of overshoot
                  if (st_reg.winCnt < target && st_reg.ncoInc != 16'hffff) begin
                     st_next.ncoInc = st_reg.ncoInc + 16'h0001; // [RULE_04]
                  end else if (st_reg.winCnt > target && st_reg.ncoInc != 16'h0000) begin
                     st_next.ncoInc = st_reg.ncoInc - 16'h0001;
                  end
               end
            end else if (st_reg.idleCnt >= 20'(RefLossCycles - 1)) begin
               st_next.holdover = 1'b1; // [RULE_11]
               st_next.locked = 1'b0;
            end else begin
               st_next.idleCnt = st_reg.idleCnt + 20'h00001;
            end
         end
      end

      // output source: bypass pin, running divider, or held low
      if (bypassSelect) begin
         st_next.outClk = port2BitClock; // [RULE_08]
      end else begin
         st_next.outClk = run && divClk; // [RULE_17]
      end

      if (rst) begin
         st_next = '0;
         st_next.awRdy = 1'b1;
         st_next.wRdy = 1'b1;
         st_next.arRdy = 1'b1;
         st_next.rRefByp = fsc_pkg::RST_REFBYP;
         st_next.rFrMode = fsc_pkg::RST_FRMODE;
      end
   end

   always_ff @(posedge ref_clk) begin
      st_reg <= st_next;
   end

   // outputs straight from the state register
   assign s_axi_awready = st_reg.awRdy;
   assign s_axi_wready = st_reg.wRdy;
   assign s_axi_bvalid = st_reg.bVld;
   assign s_axi_bresp = st_reg.bResp;
   assign s_axi_arready = st_reg.arRdy;
   assign s_axi_rvalid = st_reg.rVld;
   assign s_axi_rdata = st_reg.rData;
   assign s_axi_rresp = st_reg.rResp;
   assign synthClockOut = st_reg.outClk;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_ratio_sixteen: assert property ( // [RULE_03]
      (run && vcoTick && vcoRefRatio == 3'b110 && st_reg.ratioCnt == 5'h0f && !refTick &&
       st_reg.winCnt != 11'h7ff) |=> st_reg.winCnt == $past(st_reg.winCnt) + 11'h001)
      else $error("ratio sixteen did not close a count");
   a_int_raise: assert property ( // [RULE_04]
      (loopUpdate && st_reg.winCnt < target && st_reg.ncoInc != 16'hffff)
      |=> st_reg.ncoInc == $past(st_reg.ncoInc) + 16'h0001)
      else $error("slow oscillator was not raised");
   a_lock_match: assert property ( // [RULE_16]
      (loopUpdate && st_reg.winCnt == target) |=> st_reg.locked && $stable(st_reg.ncoInc))
      else $error("matching window did not report lock");
   a_frac_wrap: assert property ( // [RULE_05]
      (loopUpdate && fracCarry) |=> st_reg.fracAcc == $past(fracSum[15:0]) - $past(fracDenominator))
      else $error("fraction accumulator did not wrap by the denominator");
   a_frac_off: assert property ( // [RULE_06]
      (loopUpdate && !fractionalModeEnable) |=> $stable(st_reg.fracAcc))
      else $error("fraction moved in integer mode");
   a_bypass_pin: assert property ( // [RULE_08]
      bypassSelect |=> synthClockOut == $past(port2BitClock))
      else $error("bypass output does not follow the bit clock");
   a_idle_low: assert property ( // [RULE_17]
      (!run && !bypassSelect) ##1 (!run && !bypassSelect) |=> !synthClockOut)
      else $error("output active while stopped");
   a_free_inc: assert property ( // [RULE_14]
      freeRun |=> st_reg.ncoInc == (16'($past(forcedOscCode)) << fsc_pkg::FREE_SHIFT))
      else $error("free run increment differs from the forced code");
   a_free_ticks: assert property ( // [RULE_10]
      (freeRun && forcedOscCode != 6'h00) [*2] |-> ##[0:260] (vcoTick || !freeRun))
      else $error("free running oscillator produced no event");
   a_hold_freeze: assert property ( // [RULE_11]
      (run && st_reg.holdover && !freeRun && !refTick) |=> $stable(st_reg.ncoInc) && st_reg.holdover)
      else $error("holdover frequency drifted");

   c_locked: cover property (loopUpdate && st_reg.winCnt == target);
   c_holdover: cover property ($rose(st_reg.holdover));
   c_free_clock: cover property (freeRun && $rose(synthClockOut));
   c_bypass_clock: cover property (bypassSelect && $rose(synthClockOut));
endmodule
`default_nettype wire

// ---- sim/tb_frac_synth_clock_config.sv ----
`default_nettype none
module tb_frac_synth_clock_config;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [9:0] idx; logic [15:0] rstv; logic [15:0] mask;} fsc_row_t;
   logic clk = 0, rst = 1, awV = 0, wV = 0, bRdy = 0, arV = 0, rRdy = 0;
   logic mcA = 0, mcB = 0, frm = 0, bit2 = 0;
   logic [11:0] awA = '0, arA = '0;
   logic [31:0] wD = '0;
   logic [3:0] strb = 4'hf;
   logic awR, wR, bV, arR, rV, synthOut;
   logic [1:0] bR, rR, resp;
   logic [31:0] rD;
   logic [15:0] d;
   int n_errors = 0, cmp_count = 0, cnt, e;
   logic [5:0] divs [3] = '{6'h03, 6'h07, 6'h0f};
   fsc_row_t rows [7] = '{'{fsc_pkg::IDX_ENABLE, 16'h0000, fsc_pkg::MASK_ENABLE},
      '{fsc_pkg::IDX_DIVIDER, 16'h0000, fsc_pkg::MASK_DIVIDER},
      '{fsc_pkg::IDX_NUMER, 16'h0000, fsc_pkg::MASK_NUMER},
      '{fsc_pkg::IDX_INTMUL, 16'h0000, fsc_pkg::MASK_INTMUL},
      '{fsc_pkg::IDX_REFBYP, fsc_pkg::RST_REFBYP, fsc_pkg::MASK_REFBYP},
      '{fsc_pkg::IDX_DENOM, 16'h0000, fsc_pkg::MASK_DENOM},
      '{fsc_pkg::IDX_FRMODE, fsc_pkg::RST_FRMODE, fsc_pkg::MASK_FRMODE}};

   // clock, and a reference pin toggled every fourth edge, 2.5 MHz
   always #25 clk = ~clk;
   always begin
      repeat (4) @(posedge clk);
      mcA <= ~mcA;
   end

   fsc_config #(.RefLossCycles(50)) dut_u (.ref_clk(clk), .rst(rst), .s_axi_awaddr(awA),
      .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD), .s_axi_wstrb(strb),
      .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bR), .s_axi_bvalid(bV),
      .s_axi_bready(bRdy), .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arR),
      .s_axi_rdata(rD), .s_axi_rresp(rR), .s_axi_rvalid(rV), .s_axi_rready(rRdy),
      .masterClockInA(mcA), .masterClockInB(mcB), .port2FrameClock(frm),
      .port2BitClock(bit2), .synthClockOut(synthOut));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // each channel is released at the edge that takes it
   task automatic wr(input logic [9:0] idx, input logic [15:0] v, output logic [1:0] r);
      @(posedge clk);
      awA <= {idx, 2'b00};
      wD <= {16'h0000, v};
      awV <= 1'b1;
      wV <= 1'b1;
      bRdy <= 1'b1;
      do begin
         @(posedge clk);
         if (awR) awV <= 1'b0;
         if (wR) wV <= 1'b0;
      end while (bV !== 1'b1);
      bRdy <= 1'b0;
      r = bR;
   endtask

   task automatic rd(input logic [9:0] idx, output logic [15:0] v, output logic [1:0] r);
      @(posedge clk);
      arA <= {idx, 2'b00};
      arV <= 1'b1;
      rRdy <= 1'b1;
      do begin
         @(posedge clk);
         if (arR) arV <= 1'b0;
      end while (rV !== 1'b1);
      rRdy <= 1'b0;
      v = rD[15:0];
      r = rR;
   endtask

   // counts rising edges of the output over a window
   task automatic rises(input int cycles, output int n);
      logic prev;
      n = 0;
      prev = synthOut;
      repeat (cycles) begin
         @(posedge clk);
         if (synthOut === 1'b1 && prev === 1'b0) n++;
         prev = synthOut;
      end
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // watchdog, well above the few thousand cycles the tests need
   initial begin
      repeat (30000) @(posedge clk);
      n_errors++;
      end_of_test;
   end

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rises(200, cnt);
      check("idle output", cnt, 0);
      $display("test reset done");
      foreach (rows[i]) begin
         rd(rows[i].idx, d, resp);
         check("reset value", d, rows[i].rstv);
         wr(rows[i].idx, 16'hffff, resp);
         rd(rows[i].idx, d, resp);
         check("writable bits", d, rows[i].mask);
         wr(rows[i].idx, rows[i].rstv, resp);
      end
      $display("test register table done");
      wr(10'h245, 16'h1234, resp);
      check("unmapped write", resp, fsc_pkg::RESP_SLVERR);
      rd(10'h245, d, resp);
      check("unmapped read", {resp, d}, {fsc_pkg::RESP_SLVERR, 16'h0000});
      $display("test unmapped done");
      // free run with no enable: oscillator on, forced code left at its reset value
      // audio port rate settings live outside this block
      wr(fsc_pkg::IDX_ENABLE, 16'h0002, resp);
      wr(fsc_pkg::IDX_REFBYP, 16'h0cc0, resp);
      foreach (divs[i]) begin
         wr(fsc_pkg::IDX_DIVIDER, {2'b00, divs[i], 8'h06}, resp);
         rises(40, cnt);
         rises(1640, cnt);
         e = 160 / (int'(divs[i]) + 1);
         check("free run rises", (cnt >= e - 1 && cnt <= e + 1), 1);
      end
      $display("test free run done");
      wr(fsc_pkg::IDX_REFBYP, 16'h8c80, resp);
      bit2 <= 1'b1;
      repeat (6) @(posedge clk);
      check("bypass high", synthOut, 1);
      bit2 <= 1'b0;
      repeat (6) @(posedge clk);
      check("bypass low", synthOut, 0);
      wr(fsc_pkg::IDX_REFBYP, 16'h0c80, resp);
      rises(100, cnt);
      rises(200, cnt);
      check("output held", cnt, 0);
      $display("test bypass done");
      // closed loop: reference / 4 gives 32-cycle windows, N = 3 plus one half
      wr(fsc_pkg::IDX_DIVIDER, 16'h0f00, resp);
      wr(fsc_pkg::IDX_INTMUL, 16'h0060, resp);
      wr(fsc_pkg::IDX_NUMER, 16'h0001, resp);
      wr(fsc_pkg::IDX_DENOM, 16'h0002, resp);
      wr(fsc_pkg::IDX_FRMODE, 16'h0007, resp);
      wr(fsc_pkg::IDX_REFBYP, 16'h0c90, resp);
      wr(fsc_pkg::IDX_ENABLE, 16'h0001, resp);
      repeat (600) @(posedge clk);
      rd(fsc_pkg::IDX_STATUS, d, resp);
      check("loop status", d & 16'h000e, 16'h0008);
      // quiet pin as reference source stands for a lost reference
      wr(fsc_pkg::IDX_REFBYP, 16'h0c91, resp);
      repeat (100) @(posedge clk);
      rd(fsc_pkg::IDX_STATUS, d, resp);
      check("holdover status", d, 16'h000a);
      rises(500, cnt);
      check("holdover clock", (cnt >= 2 && cnt <= 4), 1);
      $display("test loop done");
      // reset again in mid-run, from holdover
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(fsc_pkg::IDX_STATUS, d, resp);
      check("status after reset", d, 16'h0000);
      rd(fsc_pkg::IDX_ENABLE, d, resp);
      check("enable after reset", d, 16'h0000);
      check("output after reset", synthOut, 0);
      $display("test mid-run reset done");
      end_of_test;
   end
endmodule
`default_nettype wire
